/* File: design/ssc_pin_sync.sv */
// ============================================================
// three-flop pin synchroniser with agreement filter
// ============================================================
// assumes: pins are asynchronous to i_mclk; idle level is high
`timescale 1ns/10ps
module ssc_pin_sync
(
  input  wire logic                       i_mclk,
  input  wire logic                       i_rst_b,
  input  wire logic [ssc_pkg::SYNC_W-1:0] i_pin,
  output logic      [ssc_pkg::SYNC_W-1:0] o_level
);
  import ssc_pkg::*;

  logic [SYNC_W-1:0] s1_r;
  logic [SYNC_W-1:0] s2_r;
  logic [SYNC_W-1:0] s3_r;
  logic [SYNC_W-1:0] level_r;

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_bit
      wire agree = (s2_r[g] == s3_r[g]);
      always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          s1_r[g]    <= SYNC_RST[g];
          s2_r[g]    <= SYNC_RST[g];
          s3_r[g]    <= SYNC_RST[g];
          level_r[g] <= SYNC_RST[g];
        end else begin
          s1_r[g] <= i_pin[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          // a change counts only once stages two and three agree
          if (agree) begin
            level_r[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate

  assign o_level = level_r;

endmodule

/* File: design/ssc_pkg.sv */
// ============================================================
// shared constants for the conversion sequencer
// ============================================================
// assumes: one system clock, pin clock sampled as an ordinary input
package ssc_pkg;

  // ============================================================
  // system clock and pin clock
  // ============================================================
  localparam int unsigned MCLK_HZ    = 50_000_000;
  localparam int unsigned PIN_CLK_HZ = 4_000_000;

  // ============================================================
  // conversion sequence, counted in pin-clock falling edges
  // ============================================================
  localparam logic [4:0] CLK_DIV      = 5'h02;
  localparam logic [4:0] CLEAR_EDGE   = 5'h01;
  localparam logic [4:0] HOLD_EDGE    = 5'h03;
  localparam logic [4:0] ACQ_EDGES    = 5'h02;
  localparam logic [4:0] FIRST_DECIDE = 5'h04;
  localparam logic [4:0] LAST_DECIDE  = 5'h12;
  localparam logic [4:0] CONV_EDGES   = 5'h14;

  // ============================================================
  // result and trial code
  // ============================================================
  localparam int unsigned RES_W       = 8;
  localparam logic [7:0]  TRIAL_RESET = 8'h80;
  localparam logic [7:0]  RESULT_RST  = 8'h00;

  // ============================================================
  // pin synchroniser
  // ============================================================
  localparam int unsigned SYNC_W   = 3;
  localparam logic [2:0]  SYNC_RST = 3'h7;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } ssc_state_t;

endpackage

/* File: design/ssc_sequencer.sv */
// ============================================================
// successive-approximation conversion sequencer
// ============================================================
// assumes: an external comparator answers for the threshold on
// o_dac_thresh; pin clock, select and read arrive asynchronously
`timescale 1ns/10ps

module ssc_sequencer
(
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_pin_clk,
  input  wire logic                 i_cs_b,
  input  wire logic                 i_rd_b,
  input  wire logic                 i_cmp_above,
  output logic                      o_hold,
  output logic                      o_conv_clk,
  output logic [ssc_pkg::RES_W:0]   o_dac_thresh,
  output logic                      o_busy_b,
  output logic [ssc_pkg::RES_W-1:0] o_data,
  output logic [ssc_pkg::RES_W-1:0] o_data_oe
);
  import ssc_pkg::*;

  // ============================================================
  // pin sampling
  // ============================================================
  logic [SYNC_W-1:0] pins_f;
  logic              clk_f;
  logic              cs_f;
  logic              rd_f;

  ssc_pin_sync u_sync (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_pin   ({i_rd_b, i_cs_b, i_pin_clk}),
    .o_level (pins_f)
  );

  assign clk_f = pins_f[0];
  assign cs_f  = pins_f[1];
  assign rd_f  = pins_f[2];

  // ============================================================
  // state
  // ============================================================
  ssc_state_t       state_r;
  ssc_state_t       state_nxt;
  logic [4:0]       edge_cnt_r;
  logic [4:0]       edge_cnt_nxt;
  logic [RES_W-1:0] trial_r;
  logic [RES_W-1:0] trial_nxt;
  logic [RES_W-1:0] mask_r;
  logic [RES_W-1:0] mask_nxt;
  logic [RES_W-1:0] result_r;
  logic [RES_W-1:0] result_nxt;
  logic             hold_r;
  logic             hold_nxt;
  logic             int_clk_r;
  logic             int_clk_nxt;
  logic             window_r;
  logic             window_nxt;
  logic             sel_q_r;
  logic             clk_q_r;

  // ============================================================
  // decode
  // ============================================================
  wire       sel       = ~cs_f & ~rd_f;
  wire       start_req = sel & ~sel_q_r;
  wire       fall      = clk_q_r & ~clk_f;
  wire       conv      = (state_r == ST_CONV);
  wire [4:0] edge_n    = edge_cnt_r + 5'h01;
  wire       at_clear  = conv & fall & (edge_n == CLEAR_EDGE);
  wire       at_hold   = conv & fall & (edge_n == HOLD_EDGE);
  // decisions ride the internal clock falling edges after acquisition
  wire       at_decide = conv & fall & ~edge_n[0] & (edge_n >= FIRST_DECIDE)
                         & (edge_n <= LAST_DECIDE);
  wire       at_done   = conv & fall & (edge_n == CONV_EDGES);
  // fresh read right after completion must not relaunch
  wire       launch    = ~conv & start_req & ~window_r;
  wire [RES_W-1:0] kept = i_cmp_above ? trial_r : (trial_r & ~mask_r);

  always_comb begin
    state_nxt    = state_r;
    edge_cnt_nxt = edge_cnt_r;
    trial_nxt    = trial_r;
    mask_nxt     = mask_r;
    result_nxt   = result_r;
    hold_nxt     = hold_r;
    int_clk_nxt  = int_clk_r;
    window_nxt   = window_r;
    case (state_r)
      ST_IDLE: begin
        hold_nxt    = 1'b0;
        int_clk_nxt = 1'b0;
        if (fall | start_req) begin
          window_nxt = 1'b0;
        end
        if (launch) begin
          state_nxt    = ST_CONV;
          edge_cnt_nxt = 5'h00;
        end
      end
      ST_CONV: begin
        if (fall) begin
          edge_cnt_nxt = edge_n;
          int_clk_nxt  = ~int_clk_r;
        end
        if (at_clear) begin
          trial_nxt = TRIAL_RESET;
          mask_nxt  = TRIAL_RESET;
        end
        if (at_hold) begin
          hold_nxt = 1'b1;
        end
        if (at_decide) begin
          trial_nxt = kept | (mask_r >> 1);
          mask_nxt  = mask_r >> 1;
        end
        if (at_done) begin
          state_nxt   = ST_IDLE;
          result_nxt  = trial_r;
          hold_nxt    = 1'b0;
          int_clk_nxt = 1'b0;
          window_nxt  = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r    <= ST_IDLE;
      edge_cnt_r <= 5'h00;
      trial_r    <= TRIAL_RESET;
      mask_r     <= TRIAL_RESET;
      result_r   <= RESULT_RST;
      hold_r     <= 1'b0;
      int_clk_r  <= 1'b0;
      window_r   <= 1'b0;
      sel_q_r    <= 1'b0;
      clk_q_r    <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      trial_r    <= trial_nxt;
      mask_r     <= mask_nxt;
      result_r   <= result_nxt;
      hold_r     <= hold_nxt;
      int_clk_r  <= int_clk_nxt;
      window_r   <= window_nxt;
      sel_q_r    <= sel;
      clk_q_r    <= clk_f;
    end
  end

  // ============================================================
  // outputs
  // ============================================================
  // threshold in half-LSB units sits half an LSB under the trial code,
  // so codes step at 1/2 LSB and at full scale minus 3/2 LSB
  assign o_dac_thresh = {trial_r, 1'b0} - 9'h001;
  assign o_hold       = hold_r;
  assign o_conv_clk   = int_clk_r;
  assign o_busy_b     = ~conv;
  // straight binary; with the bipolar network 8'h80 means zero volts
  assign o_data       = result_r;
  // old result shows during conversion; reads there leave it and the conversion undisturbed
  assign o_data_oe    = {RES_W{sel}};

  // ============================================================
  // checks
  // ============================================================
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  hold_third_edge_a: assert property (
    $rose(o_hold) |-> $past(edge_cnt_r) == HOLD_EDGE - 5'h01 && edge_cnt_r == HOLD_EDGE)
    else $error("hold not on third pin clock falling edge");

  track_when_idle_a: assert property (
    !conv |-> !o_hold)
    else $error("holding outside a conversion");

  clock_halved_a: assert property (
    conv && fall && !at_done |=> o_conv_clk != $past(o_conv_clk))
    else $error("internal clock did not follow pin clock halved");

  conv_length_a: assert property (
    $rose(o_busy_b) |-> $past(edge_cnt_r) == CONV_EDGES - 5'h01)
    else $error("conversion not twenty pin clock cycles");

  acq_before_decide_a: assert property (
    conv && $changed(mask_r) |-> edge_cnt_r >= FIRST_DECIDE || edge_cnt_r == CLEAR_EDGE)
    else $error("decision before acquisition ended");

  approx_cleared_a: assert property (
    at_clear |=> trial_r == TRIAL_RESET && mask_r == TRIAL_RESET)
    else $error("approximation register not cleared at start");

  clock_stopped_a: assert property (
    !conv ##1 !conv |-> !o_conv_clk)
    else $error("internal clock runs between conversions");

  busy_follows_conv_a: assert property (
    launch |=> !o_busy_b [*8])
    else $error("busy not low after a start");

  fresh_read_a: assert property (
    !conv && start_req && window_r |=> o_busy_b)
    else $error("read after completion relaunched");

  // the completing cycle itself latches the new result, so both ends must be busy
  result_stable_a: assert property (
    !o_busy_b ##1 !o_busy_b |-> $stable(o_data))
    else $error("result changed during conversion");

  bus_drive_a: assert property (
    o_data_oe != 8'h00 |-> !cs_f && !rd_f)
    else $error("data driven without select and read");

endmodule

/* File: verification/ssc_host_model.sv */
// host-side model: pin clock source and sampled analog front end
// assumes: analog value in half-lsb units, comparator sees held value
`timescale 1ns/10ps
module ssc_host_model (
  input  wire logic       i_slow,
  input  wire logic [8:0] i_analog,
  input  wire logic       i_hold,
  input  wire logic [8:0] i_thresh,
  output logic            o_pin_clk,
  output logic            o_cmp_above
);
  logic [8:0] held_r;

  // ============================================================
  // pin clock, free running between conversions
  // ============================================================
  // slow mode halves the rate, still legal; an unset mode runs fast
  initial begin
    o_pin_clk = 1'b0;
    forever #((i_slow === 1'b1) ? 250 : 125) o_pin_clk = ~o_pin_clk;
  end

  // ============================================================
  // track while idle, freeze while holding
  // ============================================================
  always @(i_hold or i_analog) begin
    if (!i_hold) begin
      held_r = i_analog;
    end
  end
  assign o_cmp_above = (held_r >= i_thresh);
endmodule

/* File: verification/ssc_sequencer_tb_top.sv */
// self-checking bench for the conversion sequencer
// assumes: host model supplies pin clock and comparator answer
`timescale 1ns/10ps
module ssc_sequencer_tb_top;
  import ssc_pkg::*;
  // ============================================================
  // clock, reset, bench state
  // ============================================================
  logic       mclk, rst_b, cs_b, rd_b, slow, pin_clk, cmp, hold, cclk, busy_b;
  logic [8:0] analog, thresh;
  logic [7:0] data, oe, last_code;
  int         n_errors, check_count, falls, crises;

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  always @(negedge pin_clk) falls++;
  always @(posedge cclk) crises++;

  ssc_sequencer DUT (.i_mclk(mclk), .i_rst_b(rst_b), .i_pin_clk(pin_clk), .i_cs_b(cs_b),
    .i_rd_b(rd_b), .i_cmp_above(cmp), .o_hold(hold), .o_conv_clk(cclk),
    .o_dac_thresh(thresh), .o_busy_b(busy_b), .o_data(data), .o_data_oe(oe));
  ssc_host_model host (.i_slow(slow), .i_analog(analog), .i_hold(hold),
    .i_thresh(thresh), .o_pin_clk(pin_clk), .o_cmp_above(cmp));

  // ============================================================
  // shared tasks
  // ============================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wait_lvl(input bit use_busy, input logic lvl);
    int k;
    k = 0;
    while ((use_busy ? busy_b : hold) !== lvl && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    // a wait that runs out is a failure in its own right
    if (k >= 3000) begin
      n_errors++;
      $display("wait limit reached t=%0t", $time);
    end
  endtask

  // mode 0: strobes held low, 1: read mid-conversion, 2: fresh read
  task automatic t_conv(input logic [8:0] x, input int mode);
    int         f0;
    int         c0;
    logic [7:0] code;
    code = (x >= 9'h1fd) ? 8'hff : 8'((x + 9'h001) >> 1);
    analog = x;
    // start just after a pin edge so the edge count is unambiguous
    @(negedge pin_clk);
    repeat (2) @(negedge mclk);
    f0 = falls;
    c0 = crises;
    cs_b = 1'b0;
    rd_b = 1'b0;
    wait_lvl(1'b0, 1'b1);
    check(16'(falls - f0), 16'h0003);
    check(16'(thresh), 16'h00ff);
    check(16'(busy_b), 16'h0000);
    check(16'(oe), 16'h00ff);
    analog = ~x;
    @(negedge pin_clk);
    repeat (8) @(negedge mclk);
    check(16'(thresh), (x >= 9'h0ff) ? 16'h017f : 16'h007f);
    if (mode != 0) begin
      cs_b = 1'b1;
      rd_b = 1'b1;
    end
    if (mode == 1) begin
      repeat (20) @(negedge mclk);
      cs_b = 1'b0;
      rd_b = 1'b0;
      repeat (8) @(negedge mclk);
      check(16'(data), 16'(last_code));
      check(16'(oe), 16'h00ff);
      cs_b = 1'b1;
      rd_b = 1'b1;
    end
    wait_lvl(1'b1, 1'b1);
    check(16'(falls - f0), 16'h0014);
    check(16'(crises - c0), 16'h000a);
    check(16'(data), 16'(code));
    check(16'(hold), 16'h0000);
    if (mode == 2) begin
      cs_b = 1'b0;
      rd_b = 1'b0;
    end
    c0 = crises;
    repeat (40) @(negedge mclk);
    check(16'(busy_b), 16'h0001);
    check(16'(crises - c0), 16'h0000);
    check(16'(data), 16'(code));
    check(16'(oe), (mode == 1) ? 16'h0000 : 16'h00ff);
    cs_b = 1'b1;
    rd_b = 1'b1;
    repeat (40) @(negedge mclk);
    check(16'(oe), 16'h0000);
    last_code = code;
  endtask

  // ============================================================
  // scenarios
  // ============================================================
  task automatic t_codes();
    logic [8:0] xs [8] = '{9'h000, 9'h001, 9'h002, 9'h003,
                           9'h100, 9'h1fc, 9'h1fd, 9'h1ff};
    foreach (xs[i]) begin
      t_conv(xs[i], 0);
    end
    $display("test codes done");
  endtask

  task automatic t_midread();
    t_conv(9'h0aa, 1);
    $display("test midread done");
  endtask

  task automatic t_fresh();
    t_conv(9'h155, 2);
    $display("test fresh done");
  endtask

  task automatic t_slow();
    slow = 1'b1;
    t_conv(9'h0f0, 0);
    slow = 1'b0;
    $display("test slow done");
  endtask

  initial begin
    rst_b = 1'b0;
    cs_b = 1'b1;
    rd_b = 1'b1;
    slow = 1'b0;
    analog = 9'h000;
    last_code = 8'h00;
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    check(16'(busy_b), 16'h0001);
    check(16'(oe), 16'h0000);
    repeat (8) @(negedge mclk);
    t_codes();
    t_midread();
    t_fresh();
    t_slow();
    summarize();
  end

  // 11 conversions of 5 to 10 us each, with wide margin
  initial begin
    #400_000;
    n_errors++;
    summarize();
  end
endmodule
